// ==== rtl/jtp_pkg.sv ====
/*
 * Constants of the boundary-scan test access port: instruction codes,
 * register widths and reset values.
 * Assumes nothing of its surroundings; used as jtp_pkg::name throughout.
 */
package jtp_pkg;

	// ****************************************
	// Instruction register
	// ****************************************
	localparam int IR_W = 3;
	localparam logic [2:0] IR_EXTEST = 3'h0;
	localparam logic [2:0] IR_IDCODE = 3'h1;
	localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
	localparam logic [2:0] IR_SAMPLE = 3'h4;
	// Low two bits captured into the instruction register
	localparam logic [2:0] IR_CAPTURE = 3'h1;

	// ****************************************
	// Data registers
	// ****************************************
	localparam int ID_W = 32;
	// Identification code: value is arbitrary
	localparam logic [31:0] ID_VALUE = 32'h0000_0001;
	localparam int BSR_W = 16;
	localparam int RESET_ONES = 5;

	// ****************************************
	// Controller states
	// ****************************************
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
		ST_EX2_DR, ST_UP_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR,
		ST_EX2_IR, ST_UP_IR
	} jtp_state_t;

endpackage

// ==== rtl/jtp_sync.sv ====
/*
 * Two-flop synchroniser for one external level.
 * Assumes the input is asynchronous to clk_sys.
 */
`timescale 1ns/1ps
module jtp_sync
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Level
	input wire logic din,
	input wire logic rst_val,
	output logic dout
);

	logic meta_q;
	logic sync_q;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end
		else
		begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end

	// rst_val is a constant strap tied by the parent; applied combinationally
	assign dout = sync_q ^ rst_val;

endmodule

// ==== rtl/jtp_tap.sv ====
/*
 * Boundary-scan test access port: controller, instruction register,
 * identification, bypass-free boundary scan register and serial output.
 * Assumes test pins come from outside; clk_sys runs well above the test clock
 * so that both test-clock edges are seen as sampled events.
 */
// Operation
// R1: The controller state moves only on a detected test-clock edge.
// R2: Mode select is sampled on each rising test-clock edge.
// R3: Serial data-in is sampled on the rising test-clock edge.
// R4: Serial data-out changes on the falling test-clock edge.
// R5: There is one instruction register and several selectable data registers.
// R6: Only external test and floated-capture may disturb normal memory operation.
// R7: An unused port has its clock held low and select and data-in pulled high.
// R8: Reset state is entered at power-up and after five rising edges with select high.
// R9: The three-bit instruction resets to identification and takes effect at update-IR.
// R10: The data-out driver and data-in sampling are active only in shift states.
// R11: Codes 000, 010 and 100 capture the I/O ring into the boundary register.
// R12: The controller follows the sixteen-state boundary-scan graph.
`timescale 1ns/1ps
module jtp_tap
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Test pins
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// I/O ring
	input wire logic [jtp_pkg::BSR_W-1:0] ring_in,
	output logic [jtp_pkg::BSR_W-1:0] ring_out,
	// Memory side controls
	output logic test_drive,
	output logic dq_float,
	output logic on_die_termination_off
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic tck_d1_q;
	logic rise;
	logic fall;

	// Synchronisers reset low: tck idles low, so no false edge follows reset
	jtp_sync u_tck (.clk_sys(clk_sys), .rst_n(rst_n), .din(tck), .rst_val(1'b0), .dout(tck_s));
	jtp_sync u_tms (.clk_sys(clk_sys), .rst_n(rst_n), .din(tms), .rst_val(1'b0), .dout(tms_s));
	jtp_sync u_tdi (.clk_sys(clk_sys), .rst_n(rst_n), .din(tdi), .rst_val(1'b0), .dout(tdi_s));

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			tck_d1_q <= 1'b0;
		else
			tck_d1_q <= tck_s;
	end

	assign rise = tck_s & ~tck_d1_q;
	assign fall = ~tck_s & tck_d1_q;

	// ****************************************
	// Controller
	// ****************************************
	jtp_pkg::jtp_state_t st_q;
	jtp_pkg::jtp_state_t st_d;

	// R12: standard transition graph
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			jtp_pkg::ST_RESET: st_d = tms_s ? jtp_pkg::ST_RESET : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_IDLE: st_d = tms_s ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_DR: st_d = tms_s ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
			jtp_pkg::ST_CAP_DR: st_d = tms_s ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_SH_DR: st_d = tms_s ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_EX1_DR: st_d = tms_s ? jtp_pkg::ST_UP_DR : jtp_pkg::ST_PA_DR;
			jtp_pkg::ST_PA_DR: st_d = tms_s ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PA_DR;
			jtp_pkg::ST_EX2_DR: st_d = tms_s ? jtp_pkg::ST_UP_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_UP_DR: st_d = tms_s ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_IR: st_d = tms_s ? jtp_pkg::ST_RESET : jtp_pkg::ST_CAP_IR;
			jtp_pkg::ST_CAP_IR: st_d = tms_s ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_SH_IR: st_d = tms_s ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_EX1_IR: st_d = tms_s ? jtp_pkg::ST_UP_IR : jtp_pkg::ST_PA_IR;
			jtp_pkg::ST_PA_IR: st_d = tms_s ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PA_IR;
			jtp_pkg::ST_EX2_IR: st_d = tms_s ? jtp_pkg::ST_UP_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_UP_IR: st_d = tms_s ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			default: st_d = jtp_pkg::ST_RESET;
		endcase
	end

	// R1: state moves only on a rising test clock
	// R2: select sampled at that edge
	// R8: power-up reset; five highs reach reset through the graph
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= jtp_pkg::ST_RESET;
		else if (rise)
			st_q <= st_d;
	end

	// ****************************************
	// Instruction register
	// ****************************************
	logic [jtp_pkg::IR_W-1:0] ir_sh_q;
	logic [jtp_pkg::IR_W-1:0] ir_q;

	// R5: the single instruction register
	// R9: capture loads identification code
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ir_sh_q <= jtp_pkg::IR_IDCODE;
		else if (rise)
		begin
			if (st_q == jtp_pkg::ST_CAP_IR || st_q == jtp_pkg::ST_RESET)
				ir_sh_q <= jtp_pkg::IR_CAPTURE;
			else if (st_q == jtp_pkg::ST_SH_IR)
				// R3: data-in taken in shift only
				ir_sh_q <= {tdi_s, ir_sh_q[jtp_pkg::IR_W-1:1]};
		end
	end

	// R9: takes effect at update-IR, identification in reset
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ir_q <= jtp_pkg::IR_IDCODE;
		// Loaded as soon as reset is reached, so no test mode lingers there
		else if (st_q == jtp_pkg::ST_RESET)
			ir_q <= jtp_pkg::IR_IDCODE;
		else if (rise && st_q == jtp_pkg::ST_UP_IR)
			ir_q <= ir_sh_q;
	end

	// ****************************************
	// Data registers
	// ****************************************
	logic sel_bsr;
	logic [jtp_pkg::ID_W-1:0] id_q;
	logic [jtp_pkg::BSR_W-1:0] bsr_q;
	logic [jtp_pkg::BSR_W-1:0] upd_q;

	// R11: the three ring instructions select the boundary register
	assign sel_bsr = (ir_q == jtp_pkg::IR_EXTEST) || (ir_q == jtp_pkg::IR_SAMPLE_Z)
		|| (ir_q == jtp_pkg::IR_SAMPLE);

	// R10: data-in only sampled in shift-DR
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			id_q <= jtp_pkg::ID_VALUE;
		else if (rise && !sel_bsr)
		begin
			if (st_q == jtp_pkg::ST_CAP_DR)
				id_q <= jtp_pkg::ID_VALUE;
			else if (st_q == jtp_pkg::ST_SH_DR)
				id_q <= {tdi_s, id_q[jtp_pkg::ID_W-1:1]};
		end
	end

	// R11: capture the I/O ring
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			bsr_q <= '0;
		else if (rise && sel_bsr)
		begin
			if (st_q == jtp_pkg::ST_CAP_DR)
				bsr_q <= ring_in;
			else if (st_q == jtp_pkg::ST_SH_DR)
				bsr_q <= {tdi_s, bsr_q[jtp_pkg::BSR_W-1:1]};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			upd_q <= '0;
		else if (rise && sel_bsr && st_q == jtp_pkg::ST_UP_DR)
			upd_q <= bsr_q;
	end

	assign ring_out = upd_q;

	// ****************************************
	// Memory side effects
	// ****************************************
	// R6: only external test and floated capture touch the memory pins
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			test_drive <= 1'b0;
			dq_float <= 1'b0;
			on_die_termination_off <= 1'b0;
		end
		else
		begin
			test_drive <= (ir_q == jtp_pkg::IR_EXTEST);
			dq_float <= (ir_q == jtp_pkg::IR_SAMPLE_Z);
			on_die_termination_off <= (ir_q == jtp_pkg::IR_EXTEST)
				|| (ir_q == jtp_pkg::IR_SAMPLE_Z);
		end
	end

	// ****************************************
	// Serial output
	// ****************************************
	logic sh_ir;
	logic sh_dr;
	logic tdo_d;

	assign sh_ir = (st_q == jtp_pkg::ST_SH_IR);
	assign sh_dr = (st_q == jtp_pkg::ST_SH_DR);
	assign tdo_d = sh_ir ? ir_sh_q[0] : (sel_bsr ? bsr_q[0] : id_q[0]);

	// R4: output moves on the falling test clock
	// R10: driver enabled only in shift states
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end
		else if (fall)
		begin
			tdo <= tdo_d;
			tdo_oe <= sh_ir | sh_dr;
		end
	end

endmodule

// ==== testbench/jtp_tap_chk.sv ====
/*
 * Checker: output timing of the test port against the test clock.
 * Assumes it is bound to jtp_tap and sees only its ports.
 */
`timescale 1ns/1ps
module jtp_tap_chk
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Test pins
	input wire logic tck,
	input wire logic tdo,
	input wire logic tdo_oe,
	// Memory side
	input wire logic [jtp_pkg::BSR_W-1:0] ring_out,
	input wire logic test_drive,
	input wire logic dq_float,
	input wire logic on_die_termination_off
);
	logic tck_q;
	logic [3:0] quiet_q;
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			tck_q <= 1'b0;
		else
			tck_q <= tck;
	// Synchroniser delay means outputs settle well inside eight cycles
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			quiet_q <= 4'h0;
		else if (tck != tck_q)
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hf)
			quiet_q <= quiet_q + 4'h1;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_after_fall;
		!tck || !$past(tck) || !$past(tck, 2);
	endsequence
	sequence s_after_rise;
		tck || $past(tck) || $past(tck, 2);
	endsequence
	a_tdo_on_fall: assert property ($changed(tdo) |-> s_after_fall)
		else $error("tdo moved away from a falling test clock");
	a_oe_on_fall: assert property ($changed(tdo_oe) |-> s_after_fall)
		else $error("tdo_oe moved away from a falling test clock");
	a_drive_at_update: assert property ($changed(test_drive) |-> s_after_rise)
		else $error("test_drive moved away from a rising test clock");
	a_float_at_update: assert property ($changed(dq_float) |-> s_after_rise)
		else $error("dq_float moved away from a rising test clock");
	a_ring_at_update: assert property ($changed(ring_out) |-> s_after_rise)
		else $error("ring_out moved away from a rising test clock");
	a_mode_exclusive: assert property (!(test_drive && dq_float))
		else $error("two disturbing modes at once");
	a_term_follows: assert property (on_die_termination_off == (test_drive || dq_float))
		else $error("termination control disagrees with mode");
	a_quiet_stable: assert property (quiet_q >= 4'h8 |-> $stable(tdo) && $stable(tdo_oe)
		&& $stable(ring_out) && $stable(test_drive))
		else $error("outputs moved with the test clock still");
endmodule
bind jtp_tap jtp_tap_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tdo(tdo),
	.tdo_oe(tdo_oe), .ring_out(ring_out), .test_drive(test_drive), .dq_float(dq_float),
	.on_die_termination_off(on_die_termination_off));

// ==== testbench/jtp_host.sv ====
/*
 * Test controller model: drives test clock, mode select and data in.
 * Assumes the caller starts it just after a clk_sys edge.
 */
`timescale 1ns/1ps
module jtp_host
(
	// Test pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	// clock low, select and data pulled high
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// set up half a period before the rise
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#100;
		// Undriven output reads as the inverse, so a missing enable shows
		o = tdo_oe ? tdo : ~tdo;
		tck = 1'b1;
		#100;
		tck = 1'b0;
	endtask
	// five rises with select high, then idle
	task automatic to_reset();
		logic o;
		repeat (5) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask
	// idle, capture, shift LSB first, update, idle
	task automatic scan(input bit ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		step(1'b1, 1'b1, o);
		if (ir)
			step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		dout = '0;
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask
endmodule

// ==== testbench/jtp_tap_tb.sv ====
/*
 * Testbench of the test access port.
 * Assumes jtp_host drives the test pins and the checker is bound.
 */
`timescale 1ns/1ps
module jtp_tap_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic tck, tms, tdi, tdo, tdo_oe, test_drive, dq_float, term_off;
	logic [jtp_pkg::BSR_W-1:0] ring_in = 16'ha5c3;
	logic [jtp_pkg::BSR_W-1:0] ring_out;
	logic [31:0] got;
	int n_fail = 0;
	int n_compared = 0;
	always #12.5 clk_sys = ~clk_sys;
	jtp_tap u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out),
		.test_drive(test_drive), .dq_float(dq_float), .on_die_termination_off(term_off));
	jtp_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_idcode();
		chk("tdo_oe idle", tdo_oe, 0);
		u_host.scan(1'b0, jtp_pkg::ID_W, 32'h0, got);
		chk("id", got, jtp_pkg::ID_VALUE);
	endtask
	task automatic t_sample();
		u_host.scan(1'b1, jtp_pkg::IR_W, {29'h0, jtp_pkg::IR_SAMPLE}, got);
		chk("ir capture", got, {29'h0, jtp_pkg::IR_CAPTURE});
		u_host.scan(1'b0, jtp_pkg::BSR_W, 32'h1234, got);
		chk("ring sample", got, {16'h0, ring_in});
		chk("sample mode", {test_drive, dq_float, term_off}, 0);
	endtask
	task automatic t_disturb();
		for (int k = 0; k < 2; k++)
		begin
			ring_in = 16'h3c5a ^ k[15:0];
			u_host.scan(1'b1, jtp_pkg::IR_W,
				{29'h0, k ? jtp_pkg::IR_SAMPLE_Z : jtp_pkg::IR_EXTEST}, got);
			chk("drive", test_drive, k == 0);
			chk("float", dq_float, k == 1);
			chk("term off", term_off, 1);
			u_host.scan(1'b0, jtp_pkg::BSR_W, 32'h6e21 + k, got);
			chk("ring capture", got, {16'h0, ring_in});
			chk("ring update", ring_out, 32'h6e21 + k);
		end
	endtask
	task automatic t_tms_reset();
		repeat (12) @(posedge clk_sys);
		#1;
		u_host.to_reset();
		chk("float after reset", dq_float, 0);
		u_host.scan(1'b0, jtp_pkg::ID_W, 32'h0, got);
		chk("id after reset", got, jtp_pkg::ID_VALUE);
	endtask
	task automatic t_hw_reset();
		logic o;
		u_host.scan(1'b1, jtp_pkg::IR_W, {29'h0, jtp_pkg::IR_EXTEST}, got);
		chk("drive before reset", test_drive, 1);
		rst_n = 1'b0;
		repeat (5) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		chk("drive after reset", test_drive, 0);
		repeat (12) @(posedge clk_sys);
		#1;
		// Straight from power-up reset to idle, no select-high sequence
		u_host.step(1'b0, 1'b1, o);
		u_host.scan(1'b0, jtp_pkg::ID_W, 32'h0, got);
		chk("id after power-up", got, jtp_pkg::ID_VALUE);
	endtask
	initial
	begin
		#500000;
		n_fail++;
		tally_and_finish();
	end
	initial
	begin
		repeat (5) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		repeat (12) @(posedge clk_sys);
		#1;
		u_host.to_reset();
		t_idcode();
		t_sample();
		t_disturb();
		t_tms_reset();
		t_hw_reset();
		tally_and_finish();
	end
endmodule
